/* File: rtl/ctc_timer.sv */
// Processor timer core: counter, control register, debug halt and register port
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ns

// How it works
// - Hard stop halts after next decrement; free ignores halt
// - Soft stop keeps counting, halts at zero
// - Soft stop raises zero flag at the same edge as it halts
// - Reload strobe reads zero; zero writes ignored
// - Reload strobe loads counter and prescaler
// - Stop flag: one stops, zero starts
// - Reset clears stop flag, timer runs
// - Decrement once per divide-down plus one
// - Zero flag set at zero, write one clears
module ctc_timer (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic [ctc_pkg::ADDR_W-1:0] addr,
    input  wire logic [ctc_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr_en,
    input  wire logic                       rd_en,
    output wire logic [ctc_pkg::DATA_W-1:0] rdata,
    input  wire logic                       dbg_halt,
    output wire logic                       irq
);
    import ctc_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [31:0]      count;
        logic [31:0]      period;
        logic [PSC_W-1:0] divide;
        logic             stop;
        ctc_emu_type      emu;
        ctc_hold_type     hold;
        logic [31:0]      rdata;
    } ctc_core_state_type;

    ctc_core_state_type q;
    ctc_core_state_type d;

    ctc_tick_if         tk ();
    ctc_irq_if #(.N(IRQ_N)) ir ();

    logic wr_ctrl;
    logic wr_period;
    logic wr_prescale;
    logic reload;
    logic zero_evt;
    logic halt_evt;

    // Decode a register hit for one access strobe
    function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] offs);
        hit = strobe && (a == offs);
    endfunction : hit

    // Control register image as software sees it
    function automatic logic [31:0] ctrl_image(input logic zf, input ctc_emu_type em, input logic st);
        logic [31:0] v;
        v             = 32'h00000000; // Reserved and strobe bits stay zero
        v[BIT_ZERO]   = zf;
        v[BIT_EMU_HI] = em[1];
        v[BIT_EMU_LO] = em[0];
        v[BIT_STOP]   = st;
        ctrl_image    = v;
    endfunction : ctrl_image

    // ---------------------------------------------------------------
    // Write decode
    // ---------------------------------------------------------------
    // Only the named fields are stored; everything else is dropped
    assign wr_ctrl     = hit(wr_en, addr, ADDR_CTRL);
    assign wr_period   = hit(wr_en, addr, ADDR_PERIOD);
    assign wr_prescale = hit(wr_en, addr, ADDR_PRESCALE);
    assign reload      = wr_ctrl && wdata[BIT_RELOAD];

    // ---------------------------------------------------------------
    // Counter events
    // ---------------------------------------------------------------
    // Zero is reached on the tick that takes the count from one to zero
    assign zero_evt = tk.tick && !reload && (q.count == 32'h00000001);
    // Halt entry is flagged so software can see the debugger froze the timer
    assign halt_evt = (q.hold == ST_RUN) && (d.hold == ST_HELD);

    // ---------------------------------------------------------------
    // Prescaler hookup
    // ---------------------------------------------------------------
    // The prescaler only runs while the timer is neither stopped nor held
    assign tk.enable      = !q.stop && (q.hold == ST_RUN);
    assign tk.load        = reload;
    assign tk.divide_down = q.divide;

    ctc_prescaler u_pre (
        .clk (clk),
        .rst (rst),
        .tk  (tk)
    );

    // ---------------------------------------------------------------
    // Interrupt hookup
    // ---------------------------------------------------------------
    // The control register zero bit clears the same sticky status bit
    always_comb begin
        ir.set           = '0;
        ir.set[IRQ_ZERO] = zero_evt;
        ir.set[IRQ_HALT] = halt_evt;
        ir.clr           = '0;
        if (hit(wr_en, addr, ADDR_IRQ_CLR)) begin
            ir.clr = wdata[IRQ_N-1:0];
        end
        if (wr_ctrl && wdata[BIT_ZERO]) begin
            ir.clr[IRQ_ZERO] = 1'b1;
        end
        ir.en_wr   = hit(wr_en, addr, ADDR_IRQ_EN);
        ir.en_data = wdata[IRQ_N-1:0];
    end

    ctc_irq #(.N(IRQ_N)) u_irq (
        .clk (clk),
        .rst (rst),
        .ir  (ir)
    );

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        d = q;
        // Counter: decrement per tick, wrap to period after zero
        if (tk.tick) begin
            d.count = (q.count == 32'h00000000) ? q.period : q.count - 32'h00000001;
        end
        // Reload beats a tick in the same cycle
        if (reload) begin
            d.count = q.period;
        end
        if (wr_period) begin
            d.period = wdata;
        end
        if (wr_prescale) begin
            d.divide = wdata[PSC_W-1:0];
        end
        // Control fields; a zero in the strobe bit has no effect
        if (wr_ctrl) begin
            d.stop = wdata[BIT_STOP];
            d.emu  = ctc_emu_type'(wdata[BIT_EMU_HI:BIT_EMU_LO]);
        end
        // Debug halt: held state is left as soon as the halt drops
        case (q.hold)
            ST_RUN: begin
                if (dbg_halt && !q.emu[1] && tk.tick) begin
                    if (q.emu == EMU_HARD) begin
                        d.hold = ST_HELD;
                    end else if (zero_evt) begin
                        d.hold = ST_HELD;
                    end
                end
            end
            ST_HELD: begin
                if (!dbg_halt) begin
                    d.hold = ST_RUN;
                end
            end
            default: begin
                d.hold = ST_RUN;
            end
        endcase
        // Read data stand only in the cycle after the read strobe
        d.rdata = 32'h00000000;
        if (rd_en) begin
            case (addr)
                ADDR_CTRL:     d.rdata = ctrl_image(ir.status[IRQ_ZERO], q.emu, q.stop);
                ADDR_COUNT:    d.rdata = q.count;
                ADDR_PERIOD:   d.rdata = q.period;
                ADDR_PRESCALE: d.rdata = {16'h0000, tk.prescale_count, q.divide};
                ADDR_IRQ_STAT: d.rdata = {{(32 - IRQ_N){1'b0}}, ir.status};
                ADDR_IRQ_EN:   d.rdata = {{(32 - IRQ_N){1'b0}}, ir.enable};
                default:       d.rdata = 32'h00000000;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    // Stop flag clears on reset so counting starts with no software help
    always_ff @(posedge clk) begin
        if (rst) begin
            q.count  <= COUNT_RST;
            q.period <= PERIOD_RST;
            q.divide <= DIVIDE_RST;
            q.stop   <= STOP_RST;
            q.emu    <= ctc_emu_type'(EMU_RST);
            q.hold   <= ST_RUN;
            q.rdata  <= 32'h00000000;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign irq   = ir.irq;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence hard_step_s;
        dbg_halt && q.emu == EMU_HARD && q.hold == ST_RUN && tk.tick;
    endsequence
    sequence soft_zero_s;
        dbg_halt && q.emu == EMU_SOFT && q.hold == ST_RUN && zero_evt;
    endsequence
    sequence soft_mid_s;
        q.emu == EMU_SOFT && q.hold == ST_RUN && tk.tick && !zero_evt;
    endsequence

    // Halt behaviour per emulation mode; a hard stop still lets one tick through
    // so software sees the decrement that was already under way
    hard_stop_a : assert property (hard_step_s |=> q.hold == ST_HELD ##1 (!dbg_halt || $stable(q.count)))
        else $error("hard stop did not freeze the counter");
    free_run_a : assert property (q.emu[1] && q.hold == ST_RUN |=> q.hold == ST_RUN)
        else $error("free run mode was halted");
    soft_keep_a : assert property (soft_mid_s |=> q.hold == ST_RUN)
        else $error("soft stop halted before zero");
    soft_irq_a : assert property (soft_zero_s |=> q.hold == ST_HELD && ir.status[IRQ_ZERO] && q.count == 32'h0)
        else $error("soft stop missed zero flag");
    // Register side effects
    strobe_read_a : assert property (hit(rd_en, addr, ADDR_CTRL) |=> rdata[BIT_RELOAD] == 1'b0)
        else $error("reload strobe read as one");
    reload_load_a : assert property (reload |=> q.count == q.period)
        else $error("reload did not load the period");
    stop_write_a : assert property (wr_ctrl |=> q.stop == $past(wdata[BIT_STOP]))
        else $error("stop flag write lost");
    stop_hold_a : assert property (q.stop && !reload && !wr_ctrl |=> $stable(q.count))
        else $error("counter moved while stopped");
    reset_run_a : assert property (@(posedge clk) disable iff (1'b0) rst |=> !q.stop)
        else $error("stop flag set after reset");
    decrement_a : assert property (tk.tick && !reload && q.count != 32'h0 |=> q.count == $past(q.count) - 32'h1)
        else $error("counter did not decrement by one");
    zero_flag_a : assert property (zero_evt |=> ir.status[IRQ_ZERO] && q.count == 32'h0)
        else $error("zero flag not set at zero");
    reserved_zero_a : assert property (hit(rd_en, addr, ADDR_CTRL) |=> rdata[9:6] == 4'h0 && rdata[3:0] == 4'h0)
        else $error("reserved control bits read non-zero");

    // ---------------------------------------------------------------
    // Checks on register writes and reads
    // ---------------------------------------------------------------
    // Plain storage: a write lands at the edge that takes it
    period_write_a : assert property (wr_period |=> q.period == $past(wdata))
        else $error("period write lost");
    divide_write_a : assert property (wr_prescale |=> q.divide == $past(wdata[PSC_W-1:0]))
        else $error("divide-down write lost");
    emu_write_a : assert property (wr_ctrl |=> q.emu == $past(wdata[BIT_EMU_HI:BIT_EMU_LO]))
        else $error("emulation mode write lost");
    // The counter belongs to the timer; software can only reload it
    count_ignore_a : assert property (hit(wr_en, addr, ADDR_COUNT) && !tk.tick |=> $stable(q.count))
        else $error("count register took a write");
    // Read data stand one cycle and then fall back to zero
    rdata_idle_a : assert property (!rd_en |=> rdata == 32'h0)
        else $error("read data outside read cycle");
    count_read_a : assert property (hit(rd_en, addr, ADDR_COUNT) |=> rdata == $past(q.count))
        else $error("count read wrong");
    stop_read_a : assert property (hit(rd_en, addr, ADDR_CTRL) |=> rdata[BIT_STOP] == $past(q.stop))
        else $error("stop flag read wrong");
    prescale_read_a : assert property (hit(rd_en, addr, ADDR_PRESCALE) |=> rdata[PSC_W-1:0] == $past(q.divide))
        else $error("divide-down read wrong");
    // A zero in the strobe or flag bit must leave things alone
    strobe_zero_a : assert property (wr_ctrl && !wdata[BIT_RELOAD] && !tk.tick |=> $stable(q.count))
        else $error("zero strobe write moved the counter");
    flag_keep_a : assert property (ir.status[IRQ_ZERO] && wr_ctrl && !wdata[BIT_ZERO] |=> ir.status[IRQ_ZERO])
        else $error("zero write cleared the zero flag");
    reload_psc_a : assert property (reload |=> tk.prescale_count == $past(q.divide))
        else $error("reload did not load the prescaler");

    // ---------------------------------------------------------------
    // Checks on counting and the debug halt
    // ---------------------------------------------------------------
    sequence held_s;
        q.hold == ST_HELD;
    endsequence
    // A held or stopped timer sees no tick, so only a reload moves the count
    tick_gate_a : assert property (held_s |-> !tk.tick)
        else $error("tick while held");
    stop_gate_a : assert property (q.stop |-> !tk.tick)
        else $error("tick while stopped");
    held_freeze_a : assert property (held_s ##0 !reload |=> $stable(q.count))
        else $error("counter moved while held");
    // Release is one cycle after the halt level drops
    halt_release_a : assert property (held_s ##0 !dbg_halt |=> q.hold == ST_RUN)
        else $error("hold not left after halt dropped");
    halt_flag_a : assert property (halt_evt |=> ir.status[IRQ_HALT])
        else $error("halt entry not flagged");
    halt_clear_a : assert property (ir.clr[IRQ_HALT] && !ir.set[IRQ_HALT] |=> !ir.status[IRQ_HALT])
        else $error("halt flag not cleared");
    // After the zero tick the count restarts from the period
    wrap_period_a : assert property (tk.tick && q.count == 32'h0 |=> q.count == $past(q.period))
        else $error("counter did not wrap to the period");
endmodule : ctc_timer

/* File: pkg/ctc_pkg.sv */
// Shared constants and types for the processor timer control logic
package ctc_pkg;
    // -------------------------------------------------------------
    // Bus geometry and register byte offsets
    // -------------------------------------------------------------
    localparam int         ADDR_W        = 8;
    localparam int         DATA_W        = 32;
    localparam int         PSC_W         = 8;
    localparam int         IRQ_N         = 2;
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_COUNT    = 8'h04;
    localparam logic [7:0] ADDR_PERIOD   = 8'h08;
    localparam logic [7:0] ADDR_PRESCALE = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLR  = 8'h14;
    localparam logic [7:0] ADDR_IRQ_EN   = 8'h18;
    // -------------------------------------------------------------
    // Control register field positions
    // -------------------------------------------------------------
    localparam int BIT_ZERO   = 15;
    localparam int BIT_EMU_HI = 11;
    localparam int BIT_EMU_LO = 10;
    localparam int BIT_RELOAD = 5;
    localparam int BIT_STOP   = 4;
    localparam int IRQ_ZERO   = 0;
    localparam int IRQ_HALT   = 1;
    // -------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------
    localparam logic [31:0]      PERIOD_RST = 32'hFFFFFFFF;
    localparam logic [31:0]      COUNT_RST  = 32'hFFFFFFFF;
    localparam logic [PSC_W-1:0] DIVIDE_RST = 8'h00;
    localparam logic             STOP_RST   = 1'b0;
    localparam logic [1:0]       EMU_RST    = 2'b00;
    // Debug halt behaviour and halt state
    typedef enum logic [1:0] {EMU_HARD = 2'b00, EMU_SOFT = 2'b01, EMU_FREE = 2'b10, EMU_FREE2 = 2'b11} ctc_emu_type;
    typedef enum logic {ST_RUN = 1'b0, ST_HELD = 1'b1} ctc_hold_type;
endpackage : ctc_pkg

/* File: pkg/ctc_if.sv */
// Interfaces between the timer core, its prescaler and its interrupt block
`timescale 1ns/1ns
interface ctc_tick_if;
    import ctc_pkg::*;
    logic               enable;
    logic               load;
    logic [PSC_W-1:0]   divide_down;
    logic [PSC_W-1:0]   prescale_count;
    logic               tick;
    modport pre  (input enable, load, divide_down, output tick, prescale_count);
    modport core (output enable, load, divide_down, input tick, prescale_count);
endinterface : ctc_tick_if

interface ctc_irq_if #(parameter int N = 2);
    logic [N-1:0] set;
    logic [N-1:0] clr;
    logic         en_wr;
    logic [N-1:0] en_data;
    logic [N-1:0] status;
    logic [N-1:0] enable;
    logic         irq;
    modport blk  (input set, clr, en_wr, en_data, output status, enable, irq);
    modport core (output set, clr, en_wr, en_data, input status, enable, irq);
endinterface : ctc_irq_if

/* File: rtl/ctc_prescaler.sv */
// Prescale counter that divides the timer clock source into decrement ticks
`timescale 1ns/1ns
module ctc_prescaler (
    input wire logic clk,
    input wire logic rst,
    ctc_tick_if.pre  tk
);
    import ctc_pkg::*;
    typedef struct packed {
        logic [PSC_W-1:0] psc;
    } ctc_pre_state_type;
    ctc_pre_state_type q;
    ctc_pre_state_type d;

    // Count down, reload from divide-down after reaching zero
    always_comb begin
        d = q;
        if (tk.load) begin
            d.psc = tk.divide_down;
        end else if (tk.enable) begin
            d.psc = (q.psc == '0) ? tk.divide_down : q.psc - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Tick in the source cycle while the count sits at zero; a reload swallows it
    assign tk.tick           = tk.enable && !tk.load && (q.psc == '0);
    assign tk.prescale_count = q.psc;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    psc_reload_a : assert property (tk.load |=> q.psc == $past(tk.divide_down))
        else $error("prescale count not loaded from divide-down");
    psc_rollover_a : assert property (tk.tick |=> q.psc == $past(tk.divide_down))
        else $error("prescale count not reloaded after tick");
endmodule : ctc_prescaler

/* File: rtl/ctc_irq.sv */
// Sticky interrupt status with enable register and level interrupt output
`timescale 1ns/1ns
module ctc_irq #(
    parameter int N = 2
) (
    input wire logic clk,
    input wire logic rst,
    ctc_irq_if.blk   ir
);
    import ctc_pkg::*;
    typedef struct packed {
        logic [N-1:0] status;
        logic [N-1:0] enable;
    } ctc_irq_state_type;
    ctc_irq_state_type q;
    ctc_irq_state_type d;

    // A set in the same cycle as a clear wins, so no event is lost
    always_comb begin
        d = q;
        d.status = (q.status & ~ir.clr) | ir.set;
        if (ir.en_wr) begin
            d.enable = ir.en_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ir.status = q.status;
    assign ir.enable = q.enable;
    assign ir.irq    = |(q.status & q.enable);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    set_wins_a : assert property (ir.set[IRQ_ZERO] |=> ir.status[IRQ_ZERO])
        else $error("zero event lost");
    clear_one_a : assert property (ir.clr[IRQ_ZERO] && !ir.set[IRQ_ZERO] |=> !ir.status[IRQ_ZERO])
        else $error("zero flag not cleared");
endmodule : ctc_irq

/* File: sim/ctc_emu_model.sv */
// Stand-in for the emulation logic that drives the debug halt level into the timer
`timescale 1ns/1ns
module ctc_emu_model (
    input  wire logic clk,
    input  wire logic halt_req,
    output logic      dbg_halt
);
    // -------------------------------------------------------------
    // Halt level
    // -------------------------------------------------------------
    // Low from time zero so the timer never sees an unknown halt
    initial dbg_halt = 1'b0;
    // Level changes only right after an edge, same domain as the timer
    always @(posedge clk) begin
        dbg_halt <= halt_req;
    end
endmodule : ctc_emu_model

/* File: sim/tb_ctc_timer.sv */
// Self-checking testbench for the processor timer control logic
`timescale 1ns/1ns
module tb_ctc_timer;
    import ctc_pkg::*;
    logic              clk;
    logic              rst;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr_en;
    logic              rd_en;
    logic [DATA_W-1:0] rdata;
    logic              halt_req;
    logic              dbg_halt;
    logic              irq;
    int                n_errors;
    int                samples_checked;

    ctc_timer u_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
                     .rdata(rdata), .dbg_halt(dbg_halt), .irq(irq));
    ctc_emu_model u_emu (.clk(clk), .halt_req(halt_req), .dbg_halt(dbg_halt));

    // -------------------------------------------------------------
    // Clock, watchdog and verdict
    // -------------------------------------------------------------
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Run needs well under a thousand cycles; ten thousand means a hang
    initial begin
        #40000;
        n_errors++;
        tally_and_finish();
    end
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // -------------------------------------------------------------
    // Bus and compare helpers
    // -------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // One-cycle write strobe; lowered at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    // Read data is looked at only in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] d;
        rd(a, d);
        check(name, d, exp);
    endtask : rdchk
    // Two count reads taken exactly eight cycles apart
    task automatic step(input logic [31:0] exp, input string name);
        logic [31:0] c0;
        logic [31:0] c1;
        rd(ADDR_COUNT, c0);
        repeat (6) @(posedge clk);
        rd(ADDR_COUNT, c1);
        check(name, c0 - c1, exp);
    endtask : step

    // -------------------------------------------------------------
    // Scenarios
    // -------------------------------------------------------------
    // Reset state, and counting with no software action
    task automatic t_reset;
        rdchk(ADDR_CTRL, 32'h0, "ctrl rst");
        rdchk(ADDR_PERIOD, 32'hFFFFFFFF, "period rst");
        rdchk(ADDR_PRESCALE, 32'h0, "prescale rst");
        rdchk(ADDR_IRQ_STAT, 32'h0, "stat rst");
        step(32'h8, "count runs div0");
    endtask : t_reset
    // Reload with stop, strobe and reserved bits, then restart at divide 3
    task automatic t_reload;
        wr(ADDR_PERIOD, 32'h64);
        wr(ADDR_PRESCALE, 32'h3);
        wr(ADDR_CTRL, 32'h30);
        rdchk(ADDR_COUNT, 32'h64, "count reload");
        rdchk(ADDR_PRESCALE, 32'h0303, "prescale reload");
        wr(ADDR_CTRL, 32'h0FDF);
        rdchk(ADDR_CTRL, 32'h0C10, "ctrl image");
        wr(ADDR_COUNT, 32'h5);
        rdchk(ADDR_COUNT, 32'h64, "count stopped");
        wr(ADDR_CTRL, 32'h0);
        rdchk(ADDR_CTRL, 32'h0, "ctrl running");
        step(32'h2, "count div3");
    endtask : t_reload
    // Zero flag: set on reaching zero, masked, write-zero ignored, write-one clears
    task automatic t_irq;
        wr(ADDR_CTRL, 32'h10);
        wr(ADDR_IRQ_CLR, 32'h3);
        wr(ADDR_PRESCALE, 32'h0);
        wr(ADDR_PERIOD, 32'h3);
        wr(ADDR_CTRL, 32'h30);
        wr(ADDR_CTRL, 32'h0);
        repeat (10) @(posedge clk);
        wr(ADDR_CTRL, 32'h10);
        rdchk(ADDR_IRQ_STAT, 32'h1, "zero status");
        check("irq masked", {31'h0, irq}, 32'h0);
        wr(ADDR_IRQ_EN, 32'h1);
        #1;
        check("irq on", {31'h0, irq}, 32'h1);
        wr(ADDR_CTRL, 32'h0010);
        rdchk(ADDR_CTRL, 32'h8010, "flag kept");
        wr(ADDR_CTRL, 32'h8010);
        rdchk(ADDR_CTRL, 32'h0010, "flag cleared");
        check("irq off", {31'h0, irq}, 32'h0);
        rdchk(ADDR_IRQ_CLR, 32'h0, "clr reads 0");
        rdchk(8'h40, 32'h0, "unmapped");
    endtask : t_irq
    // Hard stop freezes after the next tick; free modes ignore the halt
    task automatic t_emu(input logic [1:0] mode);
        wr(ADDR_IRQ_CLR, 32'h3);
        wr(ADDR_PRESCALE, 32'h3);
        wr(ADDR_PERIOD, 32'h64);
        wr(ADDR_CTRL, {20'h0, mode, 10'h030});
        wr(ADDR_CTRL, {20'h0, mode, 10'h000});
        halt_req <= 1'b1;
        repeat (12) @(posedge clk);
        step(mode[1] ? 32'h2 : 32'h0, "count halted");
        rdchk(ADDR_IRQ_STAT, mode[1] ? 32'h0 : 32'h2, "halt stat");
        @(posedge clk);
        halt_req <= 1'b0;
        repeat (4) @(posedge clk);
        step(32'h2, "count released");
    endtask : t_emu
    // Soft stop counts down under halt, stops at zero with the flag set
    task automatic t_soft;
        wr(ADDR_IRQ_CLR, 32'h3);
        wr(ADDR_PRESCALE, 32'h0);
        wr(ADDR_PERIOD, 32'h14);
        wr(ADDR_CTRL, 32'h0430);
        halt_req <= 1'b1;
        wr(ADDR_CTRL, 32'h0400);
        repeat (40) @(posedge clk);
        rdchk(ADDR_COUNT, 32'h0, "soft at zero");
        rdchk(ADDR_IRQ_STAT, 32'h3, "soft stat");
        check("soft irq", {31'h0, irq}, 32'h1);
        @(posedge clk);
        halt_req <= 1'b0;
        wr(ADDR_CTRL, 32'h10);
    endtask : t_soft

    // -------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------
    initial begin
        rst             = 1'b1;
        addr            = '0;
        wdata           = '0;
        wr_en           = 1'b0;
        rd_en           = 1'b0;
        halt_req        = 1'b0;
        n_errors        = 0;
        samples_checked = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_reload();
        t_irq();
        t_emu(2'b00);
        t_emu(2'b10);
        t_emu(2'b11);
        t_soft();
        tally_and_finish();
    end
endmodule : tb_ctc_timer
